// ---- src/ccspd_top.sv ----
// count source selection and single-phase pulse decode for one counter channel
`timescale 1ns/10ps
`default_nettype none

module ccspd_top (
  input  wire logic                         clk,
  input  wire logic                         rst,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output var  logic [31:0]                  prdata,
  output var  logic                         pready,
  output var  logic                         pslverr,
  // external pulse pins
  input  wire logic                         phase_a,
  input  wire logic                         phase_b,
  // neighbour counter channel
  input  wire logic [2:0]                   neighbour_mode,
  input  wire logic                         other_channel_match1_flag,
  input  wire logic                         neighbour_match1_out,
  // count enables to the counter core
  output var  logic                         count_up,
  output var  logic                         count_down
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  ccspd_pkg::ccspd_ctrl_t          ctrl;
  ccspd_pkg::ccspd_ctrl_t          next_ctrl;
  logic [ccspd_pkg::COUNT_W-1:0]   count_value;
  logic [ccspd_pkg::COUNT_W-1:0]   next_count_value;
  logic [31:0]                     next_prdata;
  logic                            next_pready;
  logic                            next_pslverr;

  // ----------------------------------------------------------------------
  // input synchronisers and edge history
  // ----------------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] hist;
  logic       a_rise;
  logic       a_fall;
  logic       b_level;
  logic       flag_rise;
  logic       pwm_rise;

  // two stages, then one more for the edge detector; stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      hist  <= 4'h0;
    end else begin
      sync1 <= {neighbour_match1_out, other_channel_match1_flag, phase_b, phase_a};
      sync2 <= sync1;
      hist  <= sync2;
    end
  end

  // edge strobes, one cycle per detected edge
  always_comb begin
    a_rise    = sync2[0] & ~hist[0];
    a_fall    = ~sync2[0] & hist[0];
    b_level   = sync2[1];
    flag_rise = sync2[2] & ~hist[2];
    pwm_rise  = sync2[3] & ~hist[3];
  end

  // ----------------------------------------------------------------------
  // internal tick prescaler
  // ----------------------------------------------------------------------
  logic [ccspd_pkg::TICK_W-1:0] tick_cnt;
  logic [ccspd_pkg::TICK_W-1:0] next_tick_cnt;
  logic [ccspd_pkg::TICK_W-1:0] tick_period;
  logic                         tick_sel;
  logic                         tick_pulse;

  // period picked by the source field; restarts whenever no tick source is live
  always_comb begin
    tick_sel = 1'b1;
    case (ctrl.src)
      ccspd_pkg::SRC_TICK_0US1:  tick_period = ccspd_pkg::TICK0_CYC;
      ccspd_pkg::SRC_TICK_1US:   tick_period = ccspd_pkg::TICK1_CYC;
      ccspd_pkg::SRC_TICK_10US:  tick_period = ccspd_pkg::TICK2_CYC;
      ccspd_pkg::SRC_TICK_100US: tick_period = ccspd_pkg::TICK3_CYC;
      default: begin
        tick_period = ccspd_pkg::TICK0_CYC;
        tick_sel    = 1'b0;
      end
    endcase
    tick_pulse = tick_sel && (tick_cnt == tick_period - 1'b1);
    if (!tick_sel || tick_pulse) begin
      next_tick_cnt = '0;
    end else begin
      next_tick_cnt = tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // source acceptance and count decode
  // ----------------------------------------------------------------------
  logic          own_normal;
  logic          src_ok;
  logic          dir_down;
  ccspd_pkg::ccspd_cnt_en_t next_en;

  // sources that are not legal for the current modes give no counts at all
  always_comb begin
    own_normal = (ctrl.mode == ccspd_pkg::OM_NORMAL);
    case (ctrl.src)
      ccspd_pkg::SRC_PHASE_AB:
        src_ok = own_normal || ctrl.mode == ccspd_pkg::OM_FREQ
                 || ctrl.mode == ccspd_pkg::OM_ROTATION;
      ccspd_pkg::SRC_OTHER_CH:
        src_ok = own_normal && (neighbour_mode == ccspd_pkg::OM_NORMAL
                 || neighbour_mode == ccspd_pkg::OM_PWM);
      ccspd_pkg::SRC_TICK_0US1, ccspd_pkg::SRC_TICK_1US,
      ccspd_pkg::SRC_TICK_10US, ccspd_pkg::SRC_TICK_100US:
        src_ok = own_normal;
      default:
        src_ok = 1'b0;
    endcase
  end

  // direction is sampled at the counted edge; relies on steady B and request there
  always_comb begin
    next_en  = '0;
    dir_down = ctrl.down_count_request;
    if (src_ok) begin
      case (ctrl.src)
        ccspd_pkg::SRC_PHASE_AB: begin
          // pulse mode only matters on this branch
          case (ctrl.pulse_mode)
            ccspd_pkg::PM_1PH_X1: begin
              dir_down     = b_level | ctrl.down_count_request;
              next_en.up   = a_rise & ~dir_down;
              next_en.down = a_fall & dir_down;
            end
            ccspd_pkg::PM_1PH_X1_A_ONLY: begin
              next_en.up   = a_rise & ~dir_down;
              next_en.down = a_fall & dir_down;
            end
            ccspd_pkg::PM_1PH_X2: begin
              dir_down     = b_level | ctrl.down_count_request;
              next_en.up   = (a_rise | a_fall) & ~dir_down;
              next_en.down = (a_rise | a_fall) & dir_down;
            end
            ccspd_pkg::PM_1PH_X2_A_ONLY: begin
              next_en.up   = (a_rise | a_fall) & ~dir_down;
              next_en.down = (a_rise | a_fall) & dir_down;
            end
            // two-phase and cw/ccw pulse modes give no count enables here
            default: next_en = '0;
          endcase
        end
        ccspd_pkg::SRC_OTHER_CH: begin
          if (neighbour_mode == ccspd_pkg::OM_PWM) begin
            next_en.up = pwm_rise;
          end else begin
            next_en.up = flag_rise;
          end
        end
        default: next_en.up = tick_pulse;
      endcase
    end
  end

  // enables leave on flops so the counter core sees clean single-cycle pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      count_up   <= 1'b0;
      count_down <= 1'b0;
    end else begin
      count_up   <= next_en.up;
      count_down <= next_en.down;
    end
  end

  // ----------------------------------------------------------------------
  // apb slave and local count value
  // ----------------------------------------------------------------------
  logic        apb_access;
  logic        apb_commit;
  logic        addr_hit;
  logic [31:0] rd_mux;

  // one wait state: pready rises on the second access cycle
  always_comb begin
    apb_access = psel & penable;
    apb_commit = apb_access & pready;
    addr_hit   = 1'b1;
    rd_mux     = 32'h0000_0000;
    case (paddr)
      ccspd_pkg::ADDR_CTRL: begin
        rd_mux[ccspd_pkg::CTRL_SRC_LSB +: 3]   = ctrl.src;
        rd_mux[ccspd_pkg::CTRL_PMODE_LSB +: 3] = ctrl.pulse_mode;
        rd_mux[ccspd_pkg::CTRL_MODE_LSB +: 3]  = ctrl.mode;
        rd_mux[ccspd_pkg::CTRL_DOWN_BIT]       = ctrl.down_count_request;
      end
      ccspd_pkg::ADDR_STATUS: begin
        rd_mux[ccspd_pkg::STAT_OK_BIT]         = src_ok;
        rd_mux[ccspd_pkg::STAT_NMODE_LSB +: 3] = neighbour_mode;
      end
      ccspd_pkg::ADDR_COUNT:  rd_mux = count_value;
      default:                addr_hit = 1'b0;
    endcase
    next_pready  = apb_access & ~pready;
    next_pslverr = apb_access & ~pready & ~addr_hit;
    next_prdata  = (apb_access & ~pready & ~pwrite) ? rd_mux : prdata;
    next_ctrl    = ctrl;
    if (apb_commit && pwrite && paddr == ccspd_pkg::ADDR_CTRL) begin
      next_ctrl.src                = ccspd_pkg::ccspd_src_t'(pwdata[ccspd_pkg::CTRL_SRC_LSB +: 3]);
      next_ctrl.pulse_mode         = ccspd_pkg::ccspd_pmode_t'(pwdata[ccspd_pkg::CTRL_PMODE_LSB +: 3]);
      next_ctrl.mode               = ccspd_pkg::ccspd_opmode_t'(pwdata[ccspd_pkg::CTRL_MODE_LSB +: 3]);
      next_ctrl.down_count_request = pwdata[ccspd_pkg::CTRL_DOWN_BIT];
    end
    // software preset wins over a count in the same cycle
    if (apb_commit && pwrite && paddr == ccspd_pkg::ADDR_COUNT) begin
      next_count_value = pwdata;
    end else if (count_up) begin
      next_count_value = count_value + 1'b1;
    end else if (count_down) begin
      next_count_value = count_value - 1'b1;
    end else begin
      next_count_value = count_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl        <= ccspd_pkg::CTRL_RESET;
      count_value <= '0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      count_value <= next_count_value;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
    end
  end

endmodule // ccspd_top

`default_nettype wire

// ---- inc/ccspd_pkg.sv ----
// package: constants, enumerations and carriers of the count source and pulse decode block
package ccspd_pkg;

  // ----------------------------------------------------------------------
  // clock and internal tick periods
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 25000;   // 40 MHz system clock
  localparam int TICK0_PERIOD_PS = 100000;  // 0.1 us
  localparam int TICK1_PERIOD_PS = 1000000; // 1 us
  localparam int TICK2_PERIOD_PS = 10000000; // 10 us
  localparam int TICK3_PERIOD_PS = 100000000; // 100 us
  localparam int TICK_W          = 12;
  localparam logic [TICK_W-1:0] TICK0_CYC = TICK_W'(TICK0_PERIOD_PS / CLK_PERIOD_PS);
  localparam logic [TICK_W-1:0] TICK1_CYC = TICK_W'(TICK1_PERIOD_PS / CLK_PERIOD_PS);
  localparam logic [TICK_W-1:0] TICK2_CYC = TICK_W'(TICK2_PERIOD_PS / CLK_PERIOD_PS);
  localparam logic [TICK_W-1:0] TICK3_CYC = TICK_W'(TICK3_PERIOD_PS / CLK_PERIOD_PS);

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;

  // control register field positions
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_PMODE_LSB = 4;
  localparam int CTRL_MODE_LSB  = 8;
  localparam int CTRL_DOWN_BIT  = 12;
  // status register field positions
  localparam int STAT_OK_BIT    = 0;
  localparam int STAT_NMODE_LSB = 4;

  // ----------------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_PHASE_AB,
    SRC_TICK_0US1,
    SRC_TICK_1US,
    SRC_TICK_10US,
    SRC_TICK_100US,
    SRC_OTHER_CH
  } ccspd_src_t;

  typedef enum logic [2:0] {
    PM_1PH_X1,
    PM_1PH_X1_A_ONLY,
    PM_1PH_X2,
    PM_1PH_X2_A_ONLY,
    PM_CW_CCW,
    PM_2PH_X1,
    PM_2PH_X2,
    PM_2PH_X4
  } ccspd_pmode_t;

  typedef enum logic [2:0] {
    OM_NORMAL,
    OM_FREQ,
    OM_ROTATION,
    OM_PULSE_MEAS,
    OM_PWM
  } ccspd_opmode_t;

  // control register carrier
  typedef struct packed {
    logic          down_count_request;
    ccspd_opmode_t mode;
    ccspd_pmode_t  pulse_mode;
    ccspd_src_t    src;
  } ccspd_ctrl_t;

  localparam ccspd_ctrl_t CTRL_RESET = '{
    down_count_request: 1'b0,
    mode:               OM_NORMAL,
    pulse_mode:         PM_1PH_X1,
    src:                SRC_PHASE_AB
  };

  // count enable pair handed to the counter core
  typedef struct packed {
    logic up;
    logic down;
  } ccspd_cnt_en_t;

  localparam int COUNT_W = 32;

endpackage

// ---- testbench/ccspd_props.sv ----
// checker: concurrent properties on the source select and pulse decode ports
`timescale 1ns/10ps
`default_nettype none
module ccspd_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        phase_a,
  input wire logic        phase_b,
  input wire logic [2:0]  neighbour_mode,
  input wire logic        other_channel_match1_flag,
  input wire logic        neighbour_match1_out,
  input wire logic        count_up,
  input wire logic        count_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // control shadow, snooped from committed writes
  // ------------------------------------------------------------
  logic [12:0] sh, next_sh;
  logic [3:0]  settle, next_settle;
  logic [2:0]  nm_q, next_nm_q;
  // settle restarts on any config change so in-flight pulses are not judged
  always_comb begin
    next_sh = sh;
    next_nm_q = neighbour_mode;
    next_settle = (settle == 4'hF) ? settle : settle + 4'h1;
    if (psel && penable && pready && pwrite && paddr == ccspd_pkg::ADDR_CTRL) begin
      next_sh = pwdata[12:0];
      next_settle = 4'h0;
    end
    if (neighbour_mode != nm_q) begin
      next_settle = 4'h0;
    end
  end
  // register the shadow
  always_ff @(posedge clk) begin
    if (rst) begin
      sh <= 13'h0000;
      settle <= 4'h0;
      nm_q <= 3'h0;
    end else begin
      sh <= next_sh;
      settle <= next_settle;
      nm_q <= next_nm_q;
    end
  end
  wire logic [2:0] s_pm = sh[6:4];
  wire logic [2:0] s_om = sh[10:8];
  wire logic       ph   = sh[2:0] == 3'h0 && settle != 4'h0;
  wire logic       oth  = sh[2:0] == 3'h5 && s_om == 3'h0 && settle != 4'h0;
  wire logic       bad  = (sh[2:0] == 3'h0 && (s_pm[2] || s_om > 3'h2)) || sh[2:0] > 3'h5
    || (sh[2:0] != 3'h0 && s_om != 3'h0)
    || (sh[2:0] == 3'h5 && neighbour_mode != 3'h0 && neighbour_mode != 3'h4);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_dir_exclusive: assert property (!(count_up && count_down))
    else $error("up and down enables together");
  a_up_single: assert property (count_up |=> !count_up)
    else $error("up enable longer than one cycle");
  a_b_down: assert property (ph && s_pm == 3'h0 && phase_b && $stable(phase_b) && $fell(phase_a)
    |-> ##[3:5] count_down) else $error("no down count with phase B high");
  a_rise_up: assert property (ph && s_pm == 3'h1 && !sh[12] && $rose(phase_a)
    |-> ##[3:5] count_up) else $error("no up count on phase A rise");
  a_fall_down: assert property (ph && s_pm == 3'h1 && sh[12] && $fell(phase_a)
    |-> ##[3:5] count_down) else $error("no down count on phase A fall");
  a_both_edges: assert property (ph && s_pm == 3'h3 && !sh[12] && $changed(phase_a)
    |-> ##[3:5] count_up) else $error("double rate edge not counted");
  a_flag_rise: assert property (oth && neighbour_mode == 3'h0 && $rose(other_channel_match1_flag)
    |-> ##[3:5] count_up) else $error("neighbour flag edge not counted");
  a_pwm_rise: assert property (oth && neighbour_mode == 3'h4 && $rose(neighbour_match1_out)
    |-> ##[3:5] count_up) else $error("neighbour output edge not counted");
  a_illegal_quiet: assert property (bad && settle > 4'h7 |-> !count_up && !count_down)
    else $error("count enable from a refused setting");
  a_tick_spacing: assert property (count_up && sh[2:0] == 3'h1 && settle > 4'h7
    |=> !count_up [*3]) else $error("short tick spacing");
endmodule // ccspd_props
bind ccspd_top ccspd_props ccspd_props_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .phase_a, .phase_b, .neighbour_mode, .other_channel_match1_flag, .neighbour_match1_out, .count_up, .count_down);
`default_nettype wire

// ---- testbench/ccspd_pulse_gen.sv ----
// partner: phase A/B pulse source standing in for an encoder
`timescale 1ns/10ps
`default_nettype none
module ccspd_pulse_gen (
  input  wire logic clk,
  output var  logic phase_a,
  output var  logic phase_b
);
  // both phases idle low from time zero
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
  end
  // B moves first and both hold gap cycles, so direction samples clean
  task automatic step(input logic a, input logic b, input int gap);
    @(posedge clk);
    phase_b <= b;
    repeat (gap) @(posedge clk);
    phase_a <= a;
    repeat (gap) @(posedge clk);
  endtask
endmodule // ccspd_pulse_gen
`default_nettype wire

// ---- testbench/ccspd_top_bench.sv ----
// testbench: source select and single-phase decode through APB and pins
`timescale 1ns/10ps
`default_nettype none
module ccspd_top_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, phase_a, phase_b, count_up, count_down, err;
  logic [2:0]  neighbour_mode = 3'h0;
  logic        other_channel_match1_flag = 1'b0;
  logic        neighbour_match1_out = 1'b0;
  int          num_errors = 0, checks_done = 0, n_up = 0, n_dn = 0, b_up, b_dn, n;
  // row: [7:5] pulse mode, [4] down request, [3] B, [2] final A, [1] up, [0] down
  localparam logic [7:0] ROWS [12] = '{8'h06, 8'h00, 8'h09, 8'h14, 8'h2E, 8'h31,
                                       8'h42, 8'h4D, 8'h6A, 8'h75, 8'h84, 8'hE8};
  localparam logic [11:0] PER [4] = '{ccspd_pkg::TICK0_CYC, ccspd_pkg::TICK1_CYC,
                                      ccspd_pkg::TICK2_CYC, ccspd_pkg::TICK3_CYC};
  always #12.5 clk = ~clk;
  // pulse tallies; compared as differences so nothing needs clearing
  always @(posedge clk) begin
    n_up <= n_up + ((count_up === 1'b1) ? 1 : 0);
    n_dn <= n_dn + ((count_down === 1'b1) ? 1 : 0);
  end
  ccspd_top ccspd_top_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .phase_a, .phase_b, .neighbour_mode, .other_channel_match1_flag, .neighbour_match1_out, .count_up, .count_down);
  ccspd_pulse_gen ccspd_pulse_gen_i (.clk, .phase_a, .phase_b);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] cw(input logic [2:0] s, input logic [2:0] p, input logic [2:0] m, input logic d);
    return {19'h0, d, 1'b0, m, 1'b0, p, 1'b0, s};
  endfunction
  // one APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      num_errors++;
      finish_test();
    end
  endtask
  // set control, move A away, then count the pulses of the return edge
  task automatic run_row(input logic [31:0] c, input logic a, input logic b, input int u, input int d, input int g);
    apb(1'b1, ccspd_pkg::ADDR_CTRL, c);
    ccspd_pulse_gen_i.step(~a, b, g);
    repeat (4) @(posedge clk);
    b_up = n_up;
    b_dn = n_dn;
    ccspd_pulse_gen_i.step(a, b, g);
    repeat (4) @(posedge clk);
    chk("up count", 32'(n_up - b_up), 32'(u));
    chk("down count", 32'(n_dn - b_dn), 32'(d));
  endtask
  // neighbour source: own mode om, neighbour mode nm, pulse on flag or output pin
  task automatic oth(input logic [2:0] om, input logic [2:0] nm, input logic pin, input int e);
    apb(1'b1, ccspd_pkg::ADDR_CTRL, cw(3'h5, 3'h0, om, 1'b0));
    neighbour_mode <= nm;
    repeat (6) @(posedge clk);
    b_up = n_up;
    if (pin) neighbour_match1_out <= 1'b1;
    else other_channel_match1_flag <= 1'b1;
    repeat (6) @(posedge clk);
    neighbour_match1_out <= 1'b0;
    other_channel_match1_flag <= 1'b0;
    repeat (6) @(posedge clk);
    chk("neighbour count", 32'(n_up - b_up), 32'(e));
    // acceptance flag and neighbour mode as software sees them
    apb(1'b0, ccspd_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status word", rd, {25'h0, nm, 3'h0, (om == 3'h0) && (nm == 3'h0 || nm == 3'h4)});
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("idle enables", {30'h0, count_up, count_down}, 32'h0000_0000);
    apb(1'b0, ccspd_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("ctrl reset", rd, 32'h0000_0000);
    apb(1'b1, ccspd_pkg::ADDR_COUNT, 32'h0000_1234);
    apb(1'b0, ccspd_pkg::ADDR_COUNT, 32'h0000_0000);
    chk("count word", rd, 32'h0000_1234);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      run_row(cw(3'h0, ROWS[i][7:5], 3'h0, ROWS[i][4]), ROWS[i][2], ROWS[i][3],
              int'(ROWS[i][1]), int'(ROWS[i][0]), 4);
    end
    run_row(cw(3'h0, 3'h0, 3'h1, 1'b0), 1'b1, 1'b0, 1, 0, 12);
    run_row(cw(3'h0, 3'h0, 3'h2, 1'b0), 1'b1, 1'b0, 1, 0, 4);
    run_row(cw(3'h0, 3'h0, 3'h3, 1'b0), 1'b1, 1'b0, 0, 0, 4);
    // each tick: nine periods and a half after one pulse hold nine more
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ccspd_pkg::ADDR_CTRL, cw(3'(k + 1), 3'h0, 3'h0, 1'b0));
      repeat (4) @(posedge clk);
      n = 0;
      while (count_up !== 1'b1 && n < 4100) begin
        @(posedge clk);
        n++;
      end
      if (n >= 4100) begin
        num_errors++;
        finish_test();
      end
      @(posedge clk);
      b_up = n_up;
      repeat (int'(PER[k]) * 19 / 2) @(posedge clk);
      chk("tick count", 32'(n_up - b_up), 32'h0000_0009);
    end
    run_row(cw(3'h1, 3'h0, 3'h1, 1'b0), 1'b1, 1'b0, 0, 0, 4);
    oth(3'h0, 3'h0, 1'b0, 1);
    oth(3'h0, 3'h4, 1'b1, 1);
    oth(3'h0, 3'h4, 1'b0, 0);
    oth(3'h0, 3'h1, 1'b0, 0);
    oth(3'h4, 3'h0, 1'b0, 0);
    // the accumulator must hold the preset plus every up pulse less every down pulse seen since
    apb(1'b0, ccspd_pkg::ADDR_COUNT, 32'h0000_0000);
    chk("count total", rd, 32'(32'h0000_1234 + n_up - n_dn));
    finish_test();
  end
endmodule // ccspd_top_bench
`default_nettype wire
